// [rtl/fars_defines.vh]
// Constants for the fault-action and analog result register pair.
// How it works
// - Bits 15-14 choose positive undervoltage response.
// - Bits 13-12 choose positive overvoltage response.
// - Bits 11-10 choose negative undervoltage response.
// - Bits 9-8 choose negative overvoltage response.
// - Bits 7-6 choose trim check fault response.
// - Bits 5-4 choose config check fault response.
// - Bits 3-2 pick clamp hold 100-400ns.
// - Bits 1-0 choose clock watch fault response.
// - Fault-action register read/write, resets to zero.
// - Result register read-only, low ten bits value.
// - Tag counts every input edge, both directions.
// - Tag copied only on valid conversion.
// - Tag wraps from 63 to 0.
`ifndef FARS_DEFINES_VH
`define FARS_DEFINES_VH
`define FARS_ADDR_W 2
`define FARS_ADDR_CFG 2'h0
`define FARS_ADDR_RES 2'h1
`define FARS_CFG_RESET 16'h0000
`define FARS_RES_RESET 16'h0000
`define FARS_POS_UV_HI 15
`define FARS_POS_UV_LO 14
`define FARS_POS_OV_HI 13
`define FARS_POS_OV_LO 12
`define FARS_NEG_UV_HI 11
`define FARS_NEG_UV_LO 10
`define FARS_NEG_OV_HI 9
`define FARS_NEG_OV_LO 8
`define FARS_TRIM_HI 7
`define FARS_TRIM_LO 6
`define FARS_CONF_HI 5
`define FARS_CONF_LO 4
`define FARS_HOLD_HI 3
`define FARS_HOLD_LO 2
`define FARS_CLKW_HI 1
`define FARS_CLKW_LO 0
`define FARS_ACT_LOW 2'h0
`define FARS_ACT_HIGH 2'h1
`define FARS_ACT_NONE 2'h3
`define FARS_ACT_RSVD 2'h2
`define FARS_RDATA_ZERO 16'h0000
`define FARS_TAG_MAX 6'h3F
`define FARS_TAG_ZERO 6'h00
`define FARS_TAG_ONE 6'h01
`define FARS_VAL_HI 9
`define FARS_TAG_HI 15
`define FARS_TAG_LO 10
`define FARS_CLK_NS 5
`define FARS_HOLD_STEP_NS 100
`define FARS_HOLD_STEP_CYC (`FARS_HOLD_STEP_NS / `FARS_CLK_NS)
`define FARS_HOLD_CNT_W 7
`define FARS_HOLD_CNT_ZERO 7'h00
`define FARS_HOLD_CNT_ONE 7'h01
`endif

// [rtl/fars_tag_counter.v]
// Edge tag counter on the non-inverting logic input.
`timescale 1ns/1ps
`default_nettype none
`include "fars_defines.vh"
module fars_tag_counter (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Logic input and count
  input wire noninverting_logic_input,
  output reg [5:0] tag_q
);
  reg last_in_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      last_in_q <= 1'b0;
      tag_q <= `FARS_TAG_ZERO;
    end else begin
      last_in_q <= noninverting_logic_input;
      if (last_in_q != noninverting_logic_input) begin
        // Six-bit sum wraps 63 to 0 by itself.
        tag_q <= tag_q + `FARS_TAG_ONE;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/fars_regs.v]
// Fault-action configuration and first analog result registers.
`timescale 1ns/1ps
`default_nettype none
`include "fars_defines.vh"
module fars_regs (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Register access port
  input wire [1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata_q,
  // Converter and logic input
  input wire conv_valid,
  input wire [9:0] analog_in1_value,
  input wire noninverting_logic_input,
  // Fault events
  input wire pos_supply_undervolt_fault,
  input wire pos_supply_overvolt_fault,
  input wire neg_supply_undervolt_fault,
  input wire neg_supply_overvolt_fault,
  input wire trim_check_fault,
  input wire config_check_fault,
  input wire clock_watch_fault,
  input wire clamp_trigger,
  // Gate outputs
  output reg gate_source_output_q,
  output reg gate_sink_output_q,
  output reg collector_emitter_clamp_q,
  // Field views
  output reg [15:0] secondary_fault_action_cfg_q,
  output reg [15:0] analog_in1_result_q
);
  // Tag counter output and the fields of the configuration register.
  wire [5:0] tag;
  wire [1:0] pos_supply_undervolt_action;
  wire [1:0] pos_supply_overvolt_action;
  wire [1:0] neg_supply_undervolt_action;
  wire [1:0] neg_supply_overvolt_action;
  wire [1:0] trim_check_fault_action;
  wire [1:0] config_check_fault_action;
  wire [1:0] clamp_hold_select;
  wire [1:0] clock_watch_fault_action;
  // Access decode.
  wire cfg_wr;

  // Merged response and next values of the registers.
  reg [1:0] act;
  reg gate_source_output_d;
  reg gate_sink_output_d;
  reg [15:0] reg_rdata_d;
  reg [15:0] secondary_fault_action_cfg_d;
  reg [15:0] analog_in1_result_d;
  reg collector_emitter_clamp_d;
  reg [`FARS_HOLD_CNT_W-1:0] hold_cnt_d;
  reg [`FARS_HOLD_CNT_W-1:0] hold_cnt_q;

  fars_tag_counter i_fars_tag_counter (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .noninverting_logic_input(noninverting_logic_input),
    .tag_q(tag)
  );

  // Any active low response beats a high one, since low is the safe gate state.
  // The reserved code counts as no action, so a stray write cannot drive the gate.
  function [1:0] merge;
    input [1:0] acc;
    input flt;
    input [1:0] code;
    begin
      if (!flt || code == `FARS_ACT_NONE || code == `FARS_ACT_RSVD)
        merge = acc;
      else if (code == `FARS_ACT_LOW)
        merge = `FARS_ACT_LOW;
      else if (acc == `FARS_ACT_LOW)
        merge = acc;
      else
        merge = `FARS_ACT_HIGH;
    end
  endfunction

  // Hold length in cycles, less one, because the set edge is already the first cycle.
  function [`FARS_HOLD_CNT_W-1:0] hold_cycles;
    input [1:0] code;
    reg [31:0] len;
    begin
      len = ({30'h0, code} + 32'h00000001) * `FARS_HOLD_STEP_CYC;
      hold_cycles = len[`FARS_HOLD_CNT_W-1:0] - `FARS_HOLD_CNT_ONE;
    end
  endfunction

  // Field views of the configuration register.
  assign pos_supply_undervolt_action =
    secondary_fault_action_cfg_q[`FARS_POS_UV_HI:`FARS_POS_UV_LO];
  assign pos_supply_overvolt_action =
    secondary_fault_action_cfg_q[`FARS_POS_OV_HI:`FARS_POS_OV_LO];
  assign neg_supply_undervolt_action =
    secondary_fault_action_cfg_q[`FARS_NEG_UV_HI:`FARS_NEG_UV_LO];
  assign neg_supply_overvolt_action =
    secondary_fault_action_cfg_q[`FARS_NEG_OV_HI:`FARS_NEG_OV_LO];
  assign trim_check_fault_action =
    secondary_fault_action_cfg_q[`FARS_TRIM_HI:`FARS_TRIM_LO];
  assign config_check_fault_action =
    secondary_fault_action_cfg_q[`FARS_CONF_HI:`FARS_CONF_LO];
  assign clamp_hold_select =
    secondary_fault_action_cfg_q[`FARS_HOLD_HI:`FARS_HOLD_LO];
  assign clock_watch_fault_action =
    secondary_fault_action_cfg_q[`FARS_CLKW_HI:`FARS_CLKW_LO];
  assign cfg_wr = reg_wr && (reg_addr == `FARS_ADDR_CFG);

  // Each fault contributes only through its own field.
  always @* begin
    act = `FARS_ACT_NONE;
    act = merge(act, pos_supply_undervolt_fault, pos_supply_undervolt_action);
    act = merge(act, pos_supply_overvolt_fault, pos_supply_overvolt_action);
    act = merge(act, neg_supply_undervolt_fault, neg_supply_undervolt_action);
    act = merge(act, neg_supply_overvolt_fault, neg_supply_overvolt_action);
    act = merge(act, trim_check_fault, trim_check_fault_action);
    act = merge(act, config_check_fault, config_check_fault_action);
    act = merge(act, clock_watch_fault, clock_watch_fault_action);
    gate_source_output_d = (act == `FARS_ACT_HIGH);
    gate_sink_output_d = (act == `FARS_ACT_LOW);
  end

  // Only the configuration register takes writes; the result register ignores them.
  always @* begin
    secondary_fault_action_cfg_d = secondary_fault_action_cfg_q;
    if (cfg_wr) begin
      secondary_fault_action_cfg_d = reg_wdata;
    end
  end

  // The counter runs on its own; only the copy into the register waits for a conversion.
  // The tag is sampled with the value, so it dates that conversion.
  always @* begin
    analog_in1_result_d = analog_in1_result_q;
    if (conv_valid) begin
      analog_in1_result_d = {tag, analog_in1_value};
    end
  end

  // Read data holds between reads; an unused address reads as zero.
  // A read in the same cycle as a write returns the old value.
  always @* begin
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        `FARS_ADDR_CFG: reg_rdata_d = secondary_fault_action_cfg_q;
        `FARS_ADDR_RES: reg_rdata_d = analog_in1_result_q;
        default: reg_rdata_d = `FARS_RDATA_ZERO;
      endcase
    end
  end

  // Hold is (code+1) steps of 100 ns; a new trigger restarts it.
  // A trigger during a hold starts the full hold again rather than adding the remainder.
  always @* begin
    collector_emitter_clamp_d = collector_emitter_clamp_q;
    hold_cnt_d = hold_cnt_q;
    if (clamp_trigger) begin
      collector_emitter_clamp_d = 1'b1;
      hold_cnt_d = hold_cycles(clamp_hold_select);
    end else if (hold_cnt_q != `FARS_HOLD_CNT_ZERO) begin
      hold_cnt_d = hold_cnt_q - `FARS_HOLD_CNT_ONE;
    end else begin
      collector_emitter_clamp_d = 1'b0;
    end
  end

  // Configuration register.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      secondary_fault_action_cfg_q <= `FARS_CFG_RESET;
    end else begin
      secondary_fault_action_cfg_q <= secondary_fault_action_cfg_d;
    end
  end

  // Result register.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      analog_in1_result_q <= `FARS_RES_RESET;
    end else begin
      analog_in1_result_q <= analog_in1_result_d;
    end
  end

  // Read data register.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= `FARS_RDATA_ZERO;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // Gate outputs are registered so a glitch in the merge logic never reaches a pin.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gate_source_output_q <= 1'b0;
      gate_sink_output_q <= 1'b0;
    end else begin
      gate_source_output_q <= gate_source_output_d;
      gate_sink_output_q <= gate_sink_output_d;
    end
  end

  // Clamp output and its hold timer.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      collector_emitter_clamp_q <= 1'b0;
      hold_cnt_q <= `FARS_HOLD_CNT_ZERO;
    end else begin
      collector_emitter_clamp_q <= collector_emitter_clamp_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end
endmodule
`default_nettype wire

// [tb/fars_host.sv]
// Host model issuing register accesses.
`timescale 1ns/1ps
`default_nettype none
module fars_host (
  // Bus
  input wire logic clk,
  input wire logic [15:0] rdata,
  output logic [1:0] addr,
  output logic wr,
  output logic rd,
  output logic [15:0] wdata
);
  initial {addr, wr, rd, wdata} = 20'h00000;
  // Host-side scaling of a result value to microvolts.
  function automatic int to_uv(input logic [9:0] v);
    return int'(v) * 32'h00000DBF;
  endfunction
  task automatic acc(input logic w, input logic [1:0] a, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge clk) {addr, wr, rd, wdata} <= {a, w, !w, d};
    // Released data is inverted so a stale value is never mistaken for a live one.
    @(posedge clk) {wr, rd, wdata} <= {2'h0, ~d};
    #1 q = rdata;
  endtask
endmodule
`default_nettype wire

// [tb/fars_regs_assertions.sv]
// Assertions for fars_regs.
`timescale 1ns/1ps
`default_nettype none
module fars_regs_chk (
  // Bus
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  // Core
  input wire logic conv_valid,
  input wire logic [9:0] analog_in1_value,
  input wire logic clamp_trigger,
  input wire logic collector_emitter_clamp_q,
  input wire logic [15:0] secondary_fault_action_cfg_q,
  input wire logic [15:0] analog_in1_result_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_cfg_write: assert property (reg_wr && reg_addr == 2'h0 |=>
    secondary_fault_action_cfg_q == $past(reg_wdata)) else $error("cfg write");
  a_cfg_keep: assert property (!(reg_wr && reg_addr == 2'h0) |=>
    $stable(secondary_fault_action_cfg_q)) else $error("cfg moved");
  a_res_load: assert property (conv_valid |=>
    analog_in1_result_q[9:0] == $past(analog_in1_value)) else $error("res load");
  a_tag_keep: assert property (!conv_valid |=>
    $stable(analog_in1_result_q)) else $error("res moved");
  a_res_ro: assert property (reg_wr && reg_addr == 2'h1 && !conv_valid |=>
    analog_in1_result_q == $past(analog_in1_result_q)) else $error("res written");
  a_clamp_on: assert property (clamp_trigger |=> collector_emitter_clamp_q [*8])
    else $error("clamp short");
  a_hold_min: assert property (clamp_trigger && secondary_fault_action_cfg_q[3:2] == 2'h0
    |-> ##21 !collector_emitter_clamp_q) else $error("hold long");
  a_hold_max: assert property (clamp_trigger && secondary_fault_action_cfg_q[3:2] == 2'h3
    |-> ##80 collector_emitter_clamp_q) else $error("hold short");
  c_conv: cover property (conv_valid);
  c_clamp: cover property (clamp_trigger);
  c_wr: cover property (reg_wr);
endmodule
bind fars_regs fars_regs_chk i_fars_regs_chk (.sys_clk, .rstn, .reg_addr, .reg_wr, .reg_wdata,
  .conv_valid, .analog_in1_value, .clamp_trigger, .collector_emitter_clamp_q,
  .secondary_fault_action_cfg_q, .analog_in1_result_q);
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for fars_regs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0, rstn = 1'b0, cv = 1'b0, inp = 1'b0, trg = 1'b0;
  logic [9:0] val = 10'h000;
  logic [6:0] f = 7'h00;
  logic [1:0] a;
  logic wr, rd, src, snk, clp;
  logic [15:0] wd, rdata, q;
  int mismatches = 0, num_checks = 0, n, p;
  always #2.5 sys_clk = ~sys_clk;
  fars_host i_fars_host (.clk(sys_clk), .rdata, .addr(a), .wr, .rd, .wdata(wd));
  fars_regs i_fars_regs (.sys_clk, .rstn, .reg_addr(a), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd),
    .reg_rdata_q(rdata), .conv_valid(cv), .analog_in1_value(val), .noninverting_logic_input(inp),
    .pos_supply_undervolt_fault(f[6]), .pos_supply_overvolt_fault(f[5]),
    .neg_supply_undervolt_fault(f[4]), .neg_supply_overvolt_fault(f[3]),
    .trim_check_fault(f[2]), .config_check_fault(f[1]), .clock_watch_fault(f[0]),
    .clamp_trigger(trg), .gate_source_output_q(src), .gate_sink_output_q(snk),
    .collector_emitter_clamp_q(clp), .secondary_fault_action_cfg_q(), .analog_in1_result_q());
  task automatic chk(input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task automatic ha(input logic w, input logic [1:0] ad, input logic [15:0] d);
    i_fars_host.acc(w, ad, d, q);
  endtask
  task automatic conclude;
    $display("%0d checks, %0d mismatches", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    ha(1'b0, 2'h0, 16'h0000);
    chk(q, 16'h0000);
    ha(1'b1, 2'h0, 16'hD7CD);
    ha(1'b1, 2'h1, 16'hFFFF);
    ha(1'b0, 2'h0, 16'h0000);
    chk(q, 16'hD7CD);
    ha(1'b0, 2'h1, 16'h0000);
    chk(q, 16'h0000);
    $display("regs done");
    // The reserved code is skipped: its response is not defined.
    for (int k = 0; k < 4; k++) begin
      if (k == 2) continue;
      for (int j = 0; j < 7; j++) begin
        // Only the field of fault j carries code k; every other field takes no action.
        p = (j == 0) ? 0 : 2 * j + 2;
        ha(1'b1, 2'h0, ~(16'h0003 << p) | (16'(k) << p));
        @(posedge sys_clk) f <= 7'h01 << j;
        repeat (2) @(posedge sys_clk);
        #1 chk(16'({src, snk}), 16'({k == 1, k == 0}));
        @(posedge sys_clk) f <= ~(7'h01 << j);
        repeat (2) @(posedge sys_clk);
        #1 chk(16'({src, snk}), 16'h0000);
        @(posedge sys_clk) f <= 7'h00;
      end
    end
    // One fault asks for high and another for low: low must win.
    ha(1'b1, 2'h0, 16'h7FFC);
    @(posedge sys_clk) f <= 7'h41;
    repeat (2) @(posedge sys_clk);
    #1 chk(16'({src, snk}), 16'h0001);
    @(posedge sys_clk) f <= 7'h00;
    $display("faults done");
    for (int h = 0; h < 4; h++) begin
      ha(1'b1, 2'h0, {12'h000, h[1:0], 2'h0});
      n = 0;
      @(posedge sys_clk) trg <= 1'b1;
      repeat (120) begin
        @(posedge sys_clk) trg <= 1'b0;
        #1 n += clp;
      end
      chk(16'(n), 16'((h + 1) * 20));
    end
    $display("clamp done");
    repeat (65) @(posedge sys_clk) inp <= ~inp;
    repeat (3) @(posedge sys_clk);
    @(posedge sys_clk) {cv, val} <= {1'b1, 10'h2A5};
    @(posedge sys_clk) {cv, val} <= {1'b0, 10'h15A};
    repeat (3) @(posedge sys_clk) inp <= ~inp;
    ha(1'b0, 2'h1, 16'h0000);
    chk(q, {6'h01, 10'h2A5});
    chk(16'(i_fars_host.to_uv(q[9:0]) / 32'h000003E8), 16'h094E);
    $display("tag done");
    // A second reset in mid-run must clear both registers again.
    @(posedge sys_clk) rstn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    ha(1'b0, 2'h0, 16'h0000);
    chk(q, 16'h0000);
    ha(1'b0, 2'h1, 16'h0000);
    chk(q, 16'h0000);
    $display("reset done");
    conclude();
  end
endmodule
`default_nettype wire
